/* File: inc/wim_pkg.sv */
package wim_pkg;

    // Clock rate and filter time.
    localparam int unsigned CLK_HZ             = 10_000_000;
    localparam int unsigned FILTER_TIME_NS     = 25_000;
    localparam int unsigned FILTER_CYCLES      = (FILTER_TIME_NS / 1000) * (CLK_HZ / 1_000_000);
    localparam int unsigned FILT_W             = 9;
    localparam logic [FILT_W-1:0] FILT_LAST    = FILT_W'(FILTER_CYCLES - 1);
    localparam logic [FILT_W-1:0] FILT_ZERO    = 9'h000;

    // Register offsets.
    localparam logic [3:0] ADDR_CTRL    = 4'h0;
    localparam logic [3:0] ADDR_STATUS  = 4'h1;
    localparam logic [3:0] ADDR_IRQ     = 4'h2;
    localparam logic [3:0] ADDR_MASK    = 4'h3;

    // Control register fields.
    localparam int CTRL_ENABLE  = 0;
    localparam int CTRL_MODE_LO = 1;
    localparam int CTRL_MODE_HI = 3;

    // Flag fields, shared by the flag and mask registers.
    localparam int FLAG_RISE = 0;
    localparam int FLAG_FALL = 1;

    localparam logic [7:0] DATA_ZERO  = 8'h00;
    localparam logic [1:0] FLAGS_ZERO = 2'h0;
    localparam logic [1:0] MASK_RESET = 2'h0;

    typedef enum logic [2:0] {
        WIM_OFF      = 3'b000,
        WIM_NORMAL   = 3'b001,
        WIM_STOP     = 3'b010,
        WIM_REPROG   = 3'b011,
        WIM_SLEEP    = 3'b100,
        WIM_FAILSAFE = 3'b101,
        WIM_RESTART  = 3'b110
    } wim_mode_t;

endpackage : wim_pkg

/* File: core/wim_core.sv */
// Overview of operation
// (R01) Both edges of the wake input count.
// (R02) Accept a level only after the filter time.
// (R03) Software enables or disables wake capability.
// (R04) Powered-off: pin undriven, wake events ignored.
// (R05) Live pin level readable in active modes.
// (R06) Enabled valid edge leaves Sleep mode.
// (R07) Fail-Safe goes to Restart on any edge.
// (R08) Active modes set edge flags, raise interrupt.
// (R09) Separate masks for rising and falling edges.
// (R10) Normal to Sleep refused while flags set.
// (R11) Pending flag wakes right after Sleep entry.
// (R12) Controller clears flags before Sleep command.
// (R13) Synchronise, filter restarts when level reverts.
//
// Decided for this implementation: strobed register access and the address map.
`timescale 1ns/100ps
module wim_core
    import wim_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       rst_n,
    input  wire logic       wake_input,
    input  wire logic [3:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    output logic            wake_input_oe,
    output logic            wake_input_out,
    output logic            wake_request,
    output logic            restart_request,
    output logic            sleep_refused,
    output logic            irq
);

    logic            sync_a;
    logic            sync_b;
    logic            filt_level;
    logic [FILT_W-1:0] filt_cnt;
    logic            edge_rise;
    logic            edge_fall;
    logic            wake_input_enable;
    wim_mode_t       mode;
    logic [1:0]      wake_edge_flags;
    logic [1:0]      mask;
    logic            wake_level_status;
    logic            active_mode;
    logic            wr_ctrl;
    logic            wr_irq;
    logic            wr_mask;
    wim_mode_t       req_mode;
    logic [1:0]      set_flags;
    logic            any_edge;
    logic            flags_pending;
    logic            sleep_blocked;
    logic            req_valid;
    logic            wr_mode;
    logic            filt_differs;
    logic            filt_done;
    logic [1:0]      clear_flags;
    logic            flags_flush;
    logic            flag_rise;
    logic            flag_fall;
    logic            req_rise;
    logic            req_fall;
    logic [7:0]      ctrl_word;
    logic [7:0]      status_word;
    logic [7:0]      flags_word;
    logic [7:0]      mask_word;
    logic [7:0]      next_rdata;

    assign active_mode = (mode == WIM_NORMAL) || (mode == WIM_STOP) || (mode == WIM_REPROG);
    assign wr_ctrl     = reg_wr && (reg_addr == ADDR_CTRL);
    assign wr_irq      = reg_wr && (reg_addr == ADDR_IRQ);
    assign wr_mask     = reg_wr && (reg_addr == ADDR_MASK);
    assign req_mode    = wim_mode_t'(reg_wdata[CTRL_MODE_HI:CTRL_MODE_LO]);
    assign any_edge    = edge_rise || edge_fall; // [R01]
    assign flags_pending = |wake_edge_flags;
    assign sleep_blocked = flags_pending || (set_flags != FLAGS_ZERO); // [R10]
    assign wr_mode       = wr_ctrl && req_valid;
    assign filt_differs  = (sync_b != filt_level);
    assign filt_done     = filt_differs && (filt_cnt == FILT_LAST); // [R02]
    assign clear_flags   = wr_irq ? reg_wdata[1:0] : FLAGS_ZERO;
    assign flags_flush   = (mode == WIM_OFF); // [R04]

    // Only codes of defined modes may be written; others leave the mode alone.
    always_comb begin
        case (req_mode)
            WIM_OFF, WIM_NORMAL, WIM_STOP, WIM_REPROG,
            WIM_SLEEP, WIM_FAILSAFE, WIM_RESTART: req_valid = 1'b1;
            default:                              req_valid = 1'b0;
        endcase
    end

    // Two-stage synchroniser on the wake input.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sync_a <= 1'b0;
            sync_b <= 1'b0;
        end else begin
            sync_a <= wake_input; // [R13]
            sync_b <= sync_a; // [R13]
        end
    end

    // Filter counter: runs while the synchronised level differs from the accepted one.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            filt_cnt <= FILT_ZERO;
        end else if (!filt_differs || filt_done) begin
            filt_cnt <= FILT_ZERO; // [R13]
        end else begin
            filt_cnt <= filt_cnt + 1'b1; // [R02]
        end
    end

    // Accepted level: a new level must persist for the filter time.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            filt_level <= 1'b0;
        end else if (filt_done) begin
            filt_level <= sync_b; // [R02]
        end
    end

    // One-cycle edge pulses in either direction.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            edge_rise <= 1'b0;
            edge_fall <= 1'b0;
        end else begin
            edge_rise <= filt_done && sync_b; // [R01]
            edge_fall <= filt_done && !sync_b; // [R01]
        end
    end

    // Wake enable bit written by software.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            wake_input_enable <= 1'b0;
        end else if (wr_ctrl) begin
            wake_input_enable <= reg_wdata[CTRL_ENABLE]; // [R03]
        end
    end

    // Chip mode: software requests, wake events leave Sleep and Fail-Safe.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            mode            <= WIM_NORMAL;
            wake_request    <= 1'b0;
            restart_request <= 1'b0;
            sleep_refused   <= 1'b0;
        end else begin
            wake_request    <= 1'b0;
            restart_request <= 1'b0;
            sleep_refused   <= 1'b0;
            case (mode)
                WIM_OFF: begin
                    if (wr_mode && req_mode != WIM_OFF) begin
                        mode <= req_mode; // [R04]
                    end
                end
                WIM_NORMAL: begin
                    if (wr_mode) begin
                        if (req_mode == WIM_SLEEP && sleep_blocked) begin
                            sleep_refused <= 1'b1; // [R10] [R12]
                        end else begin
                            mode <= req_mode;
                        end
                    end
                end
                WIM_STOP: begin
                    if (wr_mode) begin
                        mode <= req_mode;
                    end
                end
                WIM_REPROG: begin
                    if (wr_mode) begin
                        mode <= req_mode;
                    end
                end
                WIM_SLEEP: begin
                    if (wake_input_enable && (any_edge || flags_pending)) begin
                        mode         <= WIM_NORMAL; // [R06] [R11]
                        wake_request <= 1'b1;
                    end else if (wr_mode) begin
                        mode <= req_mode;
                    end
                end
                WIM_FAILSAFE: begin
                    if (any_edge) begin
                        mode            <= WIM_RESTART; // [R07]
                        restart_request <= 1'b1;
                    end else if (wr_mode) begin
                        mode <= req_mode;
                    end
                end
                WIM_RESTART: begin
                    if (wr_mode) begin
                        mode <= req_mode;
                    end
                end
                default: begin
                    mode <= WIM_NORMAL;
                end
            endcase
        end
    end

    // Edge flags: set wins over a write-one clear.
    always_comb begin
        set_flags = FLAGS_ZERO;
        if (active_mode && wake_input_enable) begin
            set_flags[FLAG_RISE] = edge_rise; // [R08]
            set_flags[FLAG_FALL] = edge_fall; // [R08]
        end
    end

    wim_flag_bit i_wim_flag_bit_rise (
        .sys_clk   (sys_clk),
        .rst_n     (rst_n),
        .flush     (flags_flush),
        .set_event (set_flags[FLAG_RISE]),
        .clear_req (clear_flags[FLAG_RISE]),
        .masked    (mask[FLAG_RISE]),
        .flag      (flag_rise),
        .request   (req_rise)
    );

    wim_flag_bit i_wim_flag_bit_fall (
        .sys_clk   (sys_clk),
        .rst_n     (rst_n),
        .flush     (flags_flush),
        .set_event (set_flags[FLAG_FALL]),
        .clear_req (clear_flags[FLAG_FALL]),
        .masked    (mask[FLAG_FALL]),
        .flag      (flag_fall),
        .request   (req_fall)
    );

    // Flag register view, one bit per edge direction.
    always_comb begin
        wake_edge_flags            = FLAGS_ZERO;
        wake_edge_flags[FLAG_RISE] = flag_rise;
        wake_edge_flags[FLAG_FALL] = flag_fall;
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            mask <= MASK_RESET;
        end else if (wr_mask) begin
            mask <= reg_wdata[1:0]; // [R09]
        end
    end

    // Interrupt level from unmasked flags.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq <= 1'b0;
        end else begin
            irq <= req_rise || req_fall; // [R08] [R09]
        end
    end

    // Live level status, held at zero outside the active modes.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            wake_level_status <= 1'b0;
        end else begin
            wake_level_status <= active_mode ? filt_level : 1'b0; // [R05]
        end
    end

    // The pin is input only, so it stays undriven in every mode.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            wake_input_oe  <= 1'b0;
            wake_input_out <= 1'b0;
        end else begin
            wake_input_oe  <= 1'b0; // [R04]
            wake_input_out <= 1'b0;
        end
    end

    // Register views built from their fields.
    always_comb begin
        ctrl_word                            = DATA_ZERO;
        ctrl_word[CTRL_ENABLE]               = wake_input_enable;
        ctrl_word[CTRL_MODE_HI:CTRL_MODE_LO] = mode;
        status_word                          = {7'h00, wake_level_status}; // [R05]
        flags_word                           = {6'h00, wake_edge_flags};
        mask_word                            = {6'h00, mask};
    end

    // Read data selection; zero outside a read.
    always_comb begin
        next_rdata = DATA_ZERO;
        if (reg_rd) begin
            case (reg_addr)
                ADDR_CTRL:   next_rdata = ctrl_word;
                ADDR_STATUS: next_rdata = status_word; // [R05]
                ADDR_IRQ:    next_rdata = flags_word;
                ADDR_MASK:   next_rdata = mask_word;
                default:     next_rdata = DATA_ZERO;
            endcase
        end
    end

    // Register read data, one cycle after the strobe.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= DATA_ZERO;
        end else begin
            reg_rdata <= next_rdata;
        end
    end

endmodule : wim_core

// One sticky event bit: an event sets it, a written one clears it, and the event wins.
module wim_flag_bit
    import wim_pkg::*;
(
    input  wire logic sys_clk,
    input  wire logic rst_n,
    input  wire logic flush,
    input  wire logic set_event,
    input  wire logic clear_req,
    input  wire logic masked,
    output logic      flag,
    output logic      request
);

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            flag <= 1'b0;
        end else if (flush) begin
            flag <= 1'b0; // [R04]
        end else if (set_event) begin
            flag <= 1'b1; // [R08]
        end else if (clear_req) begin
            flag <= 1'b0;
        end
    end

    // The request stays low while the bit is masked.
    assign request = flag && !masked; // [R09]

endmodule : wim_flag_bit

/* File: sim/wim_core_monitor.sv */
`timescale 1ns/100ps
module wim_core_monitor
    import wim_pkg::*;
(
    input wire logic       sys_clk,
    input wire logic       rst_n,
    input wire logic       wake_input,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic       wake_input_oe,
    input wire logic       wake_input_out,
    input wire logic       wake_request,
    input wire logic       restart_request,
    input wire logic       sleep_refused,
    input wire logic       irq
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    logic [8:0] stable_cnt;
    logic       last_pin;
    // Counts the cycles for which the pin has not changed.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            stable_cnt <= 9'h000;
            last_pin   <= 1'b0;
        end else begin
            last_pin   <= wake_input;
            stable_cnt <= (wake_input != last_pin) ? 9'h000 : stable_cnt + {8'h00, ~&stable_cnt};
        end
    end
    sequence s_sleep_cmd;
        $past(reg_wr) && $past(reg_addr) == ADDR_CTRL && $past(reg_wdata[3:1]) == 3'h4;
    endsequence
    sequence s_wr_recent;
        $past(reg_wr) || $past(reg_wr, 2) || $past(reg_wr, 3);
    endsequence
    AST_PIN_UNDRIVEN: assert property (!wake_input_oe && !wake_input_out)
        else $error("wake pin driven");
    AST_RD_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == DATA_ZERO)
        else $error("read data outside read cycle");
    AST_STATUS_BITS: assert property ($past(reg_rd) && $past(reg_addr) == ADDR_STATUS
        |-> reg_rdata[7:1] == 7'h00) else $error("status upper bits set");
    AST_FILTER_HOLD: assert property (restart_request |-> stable_cnt >= FILT_LAST - 9'h004)
        else $error("restart on short pulse");
    AST_RESTART_PULSE: assert property (restart_request |=> !restart_request)
        else $error("restart pulse too long");
    AST_WAKE_PULSE: assert property (wake_request |=> !wake_request)
        else $error("wake pulse too long");
    AST_REFUSE_CAUSE: assert property (sleep_refused |-> s_sleep_cmd)
        else $error("refusal without sleep command");
    AST_IRQ_HOLD: assert property ($fell(irq) |-> s_wr_recent)
        else $error("interrupt dropped without write");
endmodule : wim_core_monitor

bind wim_core wim_core_monitor i_wim_core_monitor (.sys_clk, .rst_n, .wake_input, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .wake_input_oe, .wake_input_out, .wake_request,
    .restart_request, .sleep_refused, .irq);

/* File: sim/wim_wake_source.sv */
`timescale 1ns/100ps
module wim_wake_source (
    input  wire logic level,
    input  wire logic glitch,
    output logic      wake_input
);
    // The contact bounces away from its level while glitch is held.
    assign wake_input = level ^ glitch;
endmodule : wim_wake_source

/* File: sim/tb_wim_core.sv */
`timescale 1ns/100ps
module tb_wim_core
    import wim_pkg::*;
;
    logic       sys_clk = 1'b0;
    logic       rst_n, lvl, glitch, wake_input, reg_wr, reg_rd;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata;
    logic       oe, wout, wake_request, restart_request, sleep_refused, irq;
    int         fail_count = 0;
    int         checks = 0;
    int         n;
    always #50 sys_clk = ~sys_clk;
    wim_wake_source i_wim_wake_source (.level(lvl), .glitch, .wake_input);
    wim_core i_wim_core (.sys_clk, .rst_n, .wake_input, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .wake_input_oe(oe), .wake_input_out(wout), .wake_request,
        .restart_request, .sleep_refused, .irq);
    function automatic logic [7:0] ctl(logic [2:0] m, logic en);
        return {4'h0, m, en};
    endfunction : ctl
    task check(string name, logic [7:0] seen, logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task stop_test;
        if (fail_count == 0 && checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : stop_test
    task wr(logic [3:0] a, logic [7:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask : wr
    task rd(string name, logic [3:0] a, logic [7:0] exp);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        @(negedge sys_clk);
        check(name, reg_rdata, exp);
    endtask : rd
    task pin(logic v, int hold);
        @(posedge sys_clk);
        lvl <= v;
        repeat (hold) @(posedge sys_clk);
    endtask : pin
    task wait_pulse(string name, logic [1:0] sel);
        for (n = 0; n < 300 && ({restart_request, wake_request} & sel) == 2'h0; n++)
            @(negedge sys_clk);
        check(name, {6'h00, {restart_request, wake_request} & sel}, {6'h00, sel});
    endtask : wait_pulse
    initial begin
        {rst_n, lvl, glitch, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
        void'($urandom(32'haf49));
        repeat (5) @(posedge sys_clk);
        rst_n <= 1'b1;
        rd("ctrl", ADDR_CTRL, ctl(WIM_NORMAL, 1'b0));
        rd("mask", ADDR_MASK, MASK_RESET);
        wr(4'h7, 8'hff);
        rd("unmapped", 4'h7, DATA_ZERO);
        pin(1'b1, 262);
        rd("flags off", ADDR_IRQ, DATA_ZERO);
        rd("level", ADDR_STATUS, 8'h01);
        wr(ADDR_CTRL, ctl(WIM_NORMAL, 1'b1));
        pin(1'b0, 262);
        rd("fall", ADDR_IRQ, 8'h02);
        for (int i = 0; i < 4; i++) begin
            pin(1'b0, 0);
            glitch <= 1'b1;
            repeat ((i == 0) ? FILTER_CYCLES - 1 : $urandom_range(1, 200)) @(posedge sys_clk);
            glitch <= 1'b0;
            repeat (300) @(posedge sys_clk);
            rd("glitch", ADDR_IRQ, 8'h02);
        end
        pin(1'b1, 262);
        rd("both", ADDR_IRQ, 8'h03);
        wr(ADDR_MASK, 8'h03);
        repeat (2) @(negedge sys_clk);
        check("irq masked", {7'h00, irq}, 8'h00);
        wr(ADDR_MASK, 8'h01);
        repeat (2) @(negedge sys_clk);
        check("irq fall", {7'h00, irq}, 8'h01);
        wr(ADDR_CTRL, ctl(WIM_SLEEP, 1'b1));
        @(negedge sys_clk);
        check("refused", {7'h00, sleep_refused}, 8'h01);
        rd("no sleep", ADDR_CTRL, ctl(WIM_NORMAL, 1'b1));
        wr(ADDR_IRQ, 8'h03);
        repeat (2) @(negedge sys_clk);
        check("irq clear", {7'h00, irq}, 8'h00);
        wr(ADDR_MASK, MASK_RESET);
        wr(ADDR_CTRL, ctl(WIM_SLEEP, 1'b1));
        pin(1'b0, 0);
        wait_pulse("wake", 2'h1);
        rd("awake", ADDR_CTRL, ctl(WIM_NORMAL, 1'b1));
        wr(ADDR_CTRL, ctl(WIM_STOP, 1'b1));
        pin(1'b1, 262);
        rd("stop flag", ADDR_IRQ, 8'h01);
        wr(ADDR_CTRL, ctl(WIM_SLEEP, 1'b1));
        wait_pulse("pending", 2'h1);
        wr(ADDR_IRQ, 8'h03);
        wr(ADDR_CTRL, ctl(WIM_REPROG, 1'b1));
        rd("reprog level", ADDR_STATUS, 8'h01);
        pin(1'b0, 262);
        rd("reprog flag", ADDR_IRQ, 8'h02);
        wr(ADDR_CTRL, ctl(WIM_FAILSAFE, 1'b0));
        pin(1'b1, 0);
        wait_pulse("restart", 2'h2);
        rd("restart", ADDR_CTRL, ctl(WIM_RESTART, 1'b0));
        wr(ADDR_CTRL, ctl(WIM_OFF, 1'b1));
        pin(1'b0, 262);
        rd("off flags", ADDR_IRQ, DATA_ZERO);
        rd("off level", ADDR_STATUS, DATA_ZERO);
        check("pin drive", {6'h00, oe, wout}, DATA_ZERO);
        stop_test;
    end
    initial begin
        repeat (20000) @(posedge sys_clk);
        fail_count++;
        stop_test;
    end
endmodule : tb_wim_core
